// file: logic/result_flags_defines.vh
// constants for the result event flag unit
// Overview of operation
// R1 - overflow flag when result exceeds 24 bits
// R2 - overflow flag with enable raises interrupt
// R3 - window flag set cycle after match
// R4 - window flag with enable raises interrupt
// R5 - result read clears window and ready
// R6 - unread result replaced sets overrun, interrupt
// R7 - result available sets ready, interrupt
// R8 - no ready flag on overflowed conversion
// R9 - write one clears flag, zero ignored
// R10 - hardware set beats same-cycle clear
`ifndef RESULT_FLAGS_DEFINES_VH
`define RESULT_FLAGS_DEFINES_VH

// register indices, byte address is four times the index
`define IDX_ENABLE_CLR 6'h04
`define IDX_ENABLE_SET 6'h05
`define IDX_EVENT_FLAGS 6'h06
`define IDX_RESULT 6'h07
`define IDX_WIN_MODE 6'h08
`define IDX_WIN_LOWER 6'h09
`define IDX_WIN_UPPER 6'h0A

// bit positions in the flag and enable registers
`define BIT_READY 0
`define BIT_OVERRUN 1
`define BIT_WINDOW 2
`define BIT_OVERFLOW 3
`define FLAG_COUNT 4

// widths and reset values
`define RESULT_BITS 24
`define FLAGS_RESET 4'h0
`define ENABLE_RESET 4'h0
`define WIN_MODE_RESET 3'h0
`define WIN_BOUND_RESET 24'h000000

// window monitor modes
`define WIN_OFF 3'h0
`define WIN_ABOVE 3'h1
`define WIN_BELOW 3'h2
`define WIN_INSIDE 3'h3
`define WIN_OUTSIDE 3'h4

// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: logic/event_flag_cell.v
// one sticky event flag, set by hardware, cleared by software
`timescale 1ns/1ns
`default_nettype none
module event_flag_cell (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // set and clear requests
    input wire set_req,
    input wire clr_req,
    // flag state
    output reg flag_r
);
    wire flag_nxt;

    assign flag_nxt = set_req | (flag_r & ~clr_req); // [R10]

    always @(posedge aclk) begin
        if (!aresetn) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end
endmodule
`default_nettype wire

// file: logic/result_flag_unit.v
// result event flags with window monitor behind an AXI4-Lite slave
`timescale 1ns/1ns
`default_nettype none
`include "result_flags_defines.vh"
module result_flag_unit (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // write address channel
    input wire [7:0] awaddr,
    input wire [2:0] awprot,
    input wire awvalid,
    output wire awready,
    // write data channel
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output wire wready,
    // write response channel
    output wire [1:0] bresp,
    output wire bvalid,
    input wire bready,
    // read address channel
    input wire [7:0] araddr,
    input wire [2:0] arprot,
    input wire arvalid,
    output wire arready,
    // read data channel
    output wire [31:0] rdata,
    output wire [1:0] rresp,
    output wire rvalid,
    input wire rready,
    // conversion side
    input wire conv_done,
    input wire [31:0] conv_result,
    // interrupt request
    output wire irq
);
    // register index from a byte address
    function [5:0] reg_index;
        input [7:0] addr;
        begin
            reg_index = addr[7:2];
        end
    endfunction

    // true for indices that exist
    function idx_mapped;
        input [5:0] idx;
        begin
            idx_mapped = (idx == `IDX_ENABLE_CLR) || (idx == `IDX_ENABLE_SET) ||
                         (idx == `IDX_EVENT_FLAGS) || (idx == `IDX_RESULT) ||
                         (idx == `IDX_WIN_MODE) || (idx == `IDX_WIN_LOWER) ||
                         (idx == `IDX_WIN_UPPER);
        end
    endfunction

    // byte-lane merge of a 24-bit field
    function [23:0] lane_merge;
        input [23:0] old_val;
        input [31:0] new_val;
        input [3:0] strb;
        begin
            lane_merge[7:0] = strb[0] ? new_val[7:0] : old_val[7:0];
            lane_merge[15:8] = strb[1] ? new_val[15:8] : old_val[15:8];
            lane_merge[23:16] = strb[2] ? new_val[23:16] : old_val[23:16];
        end
    endfunction

    // bus state
    reg awready_r;
    reg wready_r;
    reg bvalid_r;
    reg [1:0] bresp_r;
    reg arready_r;
    reg rvalid_r;
    reg [1:0] rresp_r;
    reg [31:0] rdata_r;
    reg aw_held_r;
    reg [5:0] aw_idx_r;
    reg w_held_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;

    // block state
    reg [`FLAG_COUNT-1:0] enable_r;
    reg [`RESULT_BITS-1:0] value_r;
    reg unread_r;
    reg win_hit_r;
    reg [2:0] win_mode_r;
    reg [`RESULT_BITS-1:0] win_lower_r;
    reg [`RESULT_BITS-1:0] win_upper_r;
    reg irq_r;
    wire [`FLAG_COUNT-1:0] flags;

    // handshake terms
    wire aw_take;
    wire w_take;
    wire ar_take;
    wire do_write;
    wire aw_held_nxt;
    wire w_held_nxt;
    wire bvalid_nxt;
    wire rvalid_nxt;
    wire [5:0] ar_idx;

    assign aw_take = awvalid & awready_r;
    assign w_take = wvalid & wready_r;
    assign ar_take = arvalid & arready_r;
    assign do_write = aw_held_r & w_held_r;
    assign aw_held_nxt = aw_take | (aw_held_r & ~do_write);
    assign w_held_nxt = w_take | (w_held_r & ~do_write);
    assign bvalid_nxt = do_write | (bvalid_r & ~bready);
    assign rvalid_nxt = ar_take | (rvalid_r & ~rready);
    assign ar_idx = reg_index(araddr);

    // write decode, strobe lane 0 carries the enable, flag and mode registers
    wire wr_lane0;
    wire wr_enable_clr;
    wire wr_enable_set;
    wire wr_flags;
    wire rd_result;

    assign wr_lane0 = do_write & wstrb_r[0];
    assign wr_enable_clr = wr_lane0 & (aw_idx_r == `IDX_ENABLE_CLR);
    assign wr_enable_set = wr_lane0 & (aw_idx_r == `IDX_ENABLE_SET);
    assign wr_flags = wr_lane0 & (aw_idx_r == `IDX_EVENT_FLAGS);
    assign rd_result = ar_take & (ar_idx == `IDX_RESULT);

    // conversion classification
    wire conv_overflow;
    wire conv_valid;
    wire win_match;

    assign conv_overflow = conv_done & (|conv_result[31:`RESULT_BITS]); // [R1]
    assign conv_valid = conv_done & ~conv_overflow; // [R8]

    reg win_cmp;
    always @* begin
        case (win_mode_r)
            `WIN_ABOVE: win_cmp = conv_result[23:0] > win_lower_r;
            `WIN_BELOW: win_cmp = conv_result[23:0] < win_upper_r;
            `WIN_INSIDE: win_cmp = (conv_result[23:0] > win_lower_r) && (conv_result[23:0] < win_upper_r);
            `WIN_OUTSIDE: win_cmp = (conv_result[23:0] < win_lower_r) || (conv_result[23:0] > win_upper_r);
            default: win_cmp = 1'b0;
        endcase
    end
    assign win_match = conv_valid & win_cmp;

    // set and clear requests per flag
    wire [`FLAG_COUNT-1:0] flag_set;
    wire [`FLAG_COUNT-1:0] flag_clr;
    wire [`FLAG_COUNT-1:0] write_clr;

    assign write_clr = wr_flags ? wdata_r[`FLAG_COUNT-1:0] : `FLAGS_RESET; // [R9]

    assign flag_set[`BIT_READY] = conv_valid; // [R7] [R8]
    assign flag_set[`BIT_OVERRUN] = conv_valid & unread_r; // [R6]
    assign flag_set[`BIT_WINDOW] = win_hit_r; // [R3]
    assign flag_set[`BIT_OVERFLOW] = conv_overflow; // [R1]

    assign flag_clr[`BIT_READY] = write_clr[`BIT_READY] | rd_result; // [R5]
    assign flag_clr[`BIT_OVERRUN] = write_clr[`BIT_OVERRUN];
    assign flag_clr[`BIT_WINDOW] = write_clr[`BIT_WINDOW] | rd_result; // [R5]
    assign flag_clr[`BIT_OVERFLOW] = write_clr[`BIT_OVERFLOW];

    genvar gi;
    generate
        for (gi = 0; gi < `FLAG_COUNT; gi = gi + 1) begin : g_flag
            event_flag_cell u_cell (
                .aclk(aclk),
                .aresetn(aresetn),
                .set_req(flag_set[gi]),
                .clr_req(flag_clr[gi]),
                .flag_r(flags[gi])
            );
        end
    endgenerate

    // result word, pending-read tracker and window pulse
    always @(posedge aclk) begin
        if (!aresetn) begin
            value_r <= `WIN_BOUND_RESET;
            unread_r <= 1'b0;
            win_hit_r <= 1'b0;
        end else begin
            win_hit_r <= win_match; // [R3]
            if (conv_valid) begin
                value_r <= conv_result[`RESULT_BITS-1:0];
            end
            // new result beats a read in the same cycle
            unread_r <= conv_valid | (unread_r & ~rd_result); // [R6]
        end
    end

    // interrupt enable pair and window configuration
    always @(posedge aclk) begin
        if (!aresetn) begin
            enable_r <= `ENABLE_RESET;
            win_mode_r <= `WIN_MODE_RESET;
            win_lower_r <= `WIN_BOUND_RESET;
            win_upper_r <= `WIN_BOUND_RESET;
        end else begin
            if (wr_enable_clr) begin
                enable_r <= enable_r & ~wdata_r[`FLAG_COUNT-1:0];
            end else if (wr_enable_set) begin
                enable_r <= enable_r | wdata_r[`FLAG_COUNT-1:0];
            end
            if (wr_lane0 && aw_idx_r == `IDX_WIN_MODE) begin
                win_mode_r <= wdata_r[2:0];
            end
            if (do_write && aw_idx_r == `IDX_WIN_LOWER) begin
                win_lower_r <= lane_merge(win_lower_r, wdata_r, wstrb_r);
            end
            if (do_write && aw_idx_r == `IDX_WIN_UPPER) begin
                win_upper_r <= lane_merge(win_upper_r, wdata_r, wstrb_r);
            end
        end
    end

    // one interrupt line from enabled flags
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(flags & enable_r); // [R2] [R4] [R6] [R7]
        end
    end

    // read data mux
    reg [31:0] rd_word;
    always @* begin
        rd_word = 32'h00000000;
        case (ar_idx)
            `IDX_ENABLE_CLR: rd_word[`FLAG_COUNT-1:0] = enable_r;
            `IDX_ENABLE_SET: rd_word[`FLAG_COUNT-1:0] = enable_r;
            `IDX_EVENT_FLAGS: rd_word[`FLAG_COUNT-1:0] = flags;
            `IDX_RESULT: rd_word[`RESULT_BITS-1:0] = value_r;
            `IDX_WIN_MODE: rd_word[2:0] = win_mode_r;
            `IDX_WIN_LOWER: rd_word[`RESULT_BITS-1:0] = win_lower_r;
            `IDX_WIN_UPPER: rd_word[`RESULT_BITS-1:0] = win_upper_r;
            default: rd_word = 32'h00000000;
        endcase
    end

    // write channels: address and data taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= `RESP_OKAY;
            aw_held_r <= 1'b0;
            aw_idx_r <= 6'h00;
            w_held_r <= 1'b0;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
        end else begin
            aw_held_r <= aw_held_nxt;
            w_held_r <= w_held_nxt;
            bvalid_r <= bvalid_nxt;
            awready_r <= ~aw_held_nxt & ~bvalid_nxt;
            wready_r <= ~w_held_nxt & ~bvalid_nxt;
            if (aw_take) begin
                aw_idx_r <= reg_index(awaddr);
            end
            if (w_take) begin
                wdata_r <= wdata;
                wstrb_r <= wstrb;
            end
            if (do_write) begin
                bresp_r <= idx_mapped(aw_idx_r) ? `RESP_OKAY : `RESP_SLVERR;
            end
        end
    end

    // read channels
    always @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rresp_r <= `RESP_OKAY;
            rdata_r <= 32'h00000000;
        end else begin
            rvalid_r <= rvalid_nxt;
            arready_r <= ~rvalid_nxt;
            if (ar_take) begin
                rdata_r <= rd_word;
                rresp_r <= idx_mapped(ar_idx) ? `RESP_OKAY : `RESP_SLVERR;
            end
        end
    end

    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rresp = rresp_r;
    assign rdata = rdata_r;
    assign irq = irq_r;
endmodule
`default_nettype wire

// file: testbench/result_flag_checker_assertions.sv
// port checker for the result flag unit
`timescale 1ns/1ns
`default_nettype none
`include "result_flags_defines.vh"
module result_flag_checker (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // bus side
    input wire awready,
    input wire [1:0] bresp,
    input wire bvalid,
    input wire bready,
    input wire [7:0] araddr,
    input wire arvalid,
    input wire arready,
    input wire [31:0] rdata,
    input wire [1:0] rresp,
    input wire rvalid,
    input wire rready,
    // conversion and interrupt
    input wire conv_done,
    input wire irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire rd_take = arvalid && arready;
    a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer dropped");
    a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read answer dropped");
    a_read_answer: assert property (rd_take |=> rvalid) else $error("read not answered");
    a_bad_read: assert property (rd_take && araddr[7:2] == 6'h00 |=> rresp == `RESP_SLVERR && rdata == 32'h0)
        else $error("unmapped read answered");
    a_flag_width: assert property (rd_take && araddr[7:2] == `IDX_EVENT_FLAGS |=> rdata[31:4] == 28'h0)
        else $error("flag upper bits set");
    a_write_done: assert property (bvalid && bready |=> !bvalid) else $error("write answer stuck");
    a_aw_closed: assert property (bvalid |-> !awready) else $error("address taken during answer");
    a_irq_cause: assert property ($rose(irq) |-> $past(conv_done, 2) || $past(conv_done, 3) || $past(bvalid))
        else $error("interrupt without cause");
    cover property (rd_take && araddr[7:2] == `IDX_RESULT);
    cover property ($rose(irq));
    cover property (bvalid && bready && bresp == `RESP_SLVERR);
endmodule
bind result_flag_unit result_flag_checker chk_i (.aclk, .aresetn, .awready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .conv_done, .irq);
`default_nettype wire

// file: testbench/test_result_flag_unit.sv
// self-checking bench for the result flag unit
`timescale 1ns/1ns
`default_nettype none
`include "result_flags_defines.vh"
module test_result_flag_unit;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
    logic rready = 1'b0, conv_done = 1'b0, awready, wready, bvalid, arready, rvalid, irq;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [2:0] awprot = 3'h0, arprot = 3'h0;
    logic [3:0] wstrb = 4'hF;
    logic [31:0] wdata = 32'h0, conv_result = 32'h0, rdata, rv;
    logic [1:0] bresp, rresp, br, rr;
    int mismatches = 0, tests_run = 0;
    result_flag_unit dut (.aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .conv_done, .conv_result, .irq);
    always #50 aclk = ~aclk;
    task chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task wr(input logic [5:0] i, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= {i, 2'b00};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        br = bresp;
        bready <= 1'b0;
    endtask
    task rd(input logic [5:0] i);
        @(posedge aclk);
        araddr <= {i, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rv = rdata;
        rr = rresp;
        rready <= 1'b0;
    endtask
    task cv(input logic [31:0] v);
        @(posedge aclk);
        conv_done <= 1'b1;
        conv_result <= v;
        @(posedge aclk);
        conv_done <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask
    task t_reset;
        for (int i = 4; i <= 10; i++) begin
            rd(6'(i));
            chk(rv, 32'h0);
            chk({30'h0, rr}, 32'h0);
        end
    endtask
    task t_ready;
        wr(`IDX_ENABLE_SET, 32'hF);
        cv(32'h000123);
        chk(32'(irq), 32'h1);
        rd(`IDX_EVENT_FLAGS);
        chk(rv, 32'h1);
        rd(`IDX_RESULT);
        chk(rv, 32'h123);
        rd(`IDX_EVENT_FLAGS);
        chk(rv, 32'h0);
    endtask
    task t_overrun;
        cv(32'h10);
        cv(32'h20);
        rd(`IDX_EVENT_FLAGS);
        chk(rv, 32'h3);
        wr(`IDX_EVENT_FLAGS, 32'h0);
        rd(`IDX_EVENT_FLAGS);
        chk(rv, 32'h3);
        wr(`IDX_EVENT_FLAGS, 32'h2);
        rd(`IDX_EVENT_FLAGS);
        chk(rv, 32'h1);
        rd(`IDX_RESULT);
    endtask
    task t_overflow;
        cv(32'h01000000);
        chk(32'(irq), 32'h1);
        rd(`IDX_EVENT_FLAGS);
        chk(rv, 32'h8);
        rd(`IDX_RESULT);
        chk(rv, 32'h20);
        wr(`IDX_EVENT_FLAGS, 32'h8);
        rd(`IDX_EVENT_FLAGS);
        chk(rv, 32'h0);
    endtask
    task t_window;
        logic [4:0] hit;
        hit = 5'b01110;
        wr(`IDX_WIN_LOWER, 32'h10);
        wr(`IDX_WIN_UPPER, 32'h20);
        for (int m = 0; m <= 4; m++) begin
            wr(`IDX_WIN_MODE, 32'(m));
            cv(32'h15);
            rd(`IDX_EVENT_FLAGS);
            chk(rv, hit[m] ? 32'h5 : 32'h1);
            rd(`IDX_RESULT);
            rd(`IDX_EVENT_FLAGS);
            chk(rv, 32'h0);
        end
    endtask
    task t_mask;
        wr(`IDX_ENABLE_CLR, 32'hB);
        wr(`IDX_WIN_MODE, 32'h3);
        cv(32'h15);
        chk(32'(irq), 32'h1);
        rd(`IDX_RESULT);
        wr(`IDX_WIN_MODE, 32'h0);
        cv(32'h15);
        chk(32'(irq), 32'h0);
        rd(`IDX_ENABLE_SET);
        chk(rv, 32'h4);
    endtask
    // new result lands on the edge of a write-one clear, then of a result read
    task t_race;
        fork
            wr(`IDX_EVENT_FLAGS, 32'h1);
            begin
                repeat (2) @(posedge aclk);
                conv_done <= 1'b1;
                conv_result <= 32'h44;
                @(posedge aclk);
                conv_done <= 1'b0;
            end
        join
        repeat (2) @(posedge aclk);
        rd(`IDX_EVENT_FLAGS);
        chk(rv, 32'h3);
        wr(`IDX_EVENT_FLAGS, 32'h3);
        fork
            rd(`IDX_RESULT);
            begin
                @(posedge aclk);
                conv_done <= 1'b1;
                conv_result <= 32'h55;
                @(posedge aclk);
                conv_done <= 1'b0;
            end
        join
        chk(rv, 32'h44);
        repeat (2) @(posedge aclk);
        rd(`IDX_EVENT_FLAGS);
        chk(rv, 32'h3);
    endtask
    task t_bad;
        rd(6'h00);
        chk({30'h0, rr}, 32'h2);
        chk(rv, 32'h0);
        wr(6'h3F, 32'hF);
        chk({30'h0, br}, 32'h2);
        wr(`IDX_RESULT, 32'hFFFFFF);
        chk({30'h0, br}, 32'h0);
        rd(`IDX_RESULT);
        chk(rv, 32'h55);
    endtask
    task complete_run;
        if (mismatches == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_reset;
        t_ready;
        t_overrun;
        t_overflow;
        t_window;
        t_mask;
        t_race;
        t_bad;
        complete_run;
    end
    initial begin
        repeat (5000) @(posedge aclk);
        mismatches++;
        complete_run;
    end
endmodule
`default_nettype wire
